// File: verilog/pea_pkg.sv
// Constants, timing figures and state codes shared by the parallel memory host controller.
package pea_pkg;

  // Pin widths and page layout of the attached 8K x 8 memory.
  localparam int ADDR_W     = 13;
  localparam int DATA_W     = 8;
  localparam int PAGE_LSB   = 6;
  localparam int PAGE_W     = ADDR_W - PAGE_LSB;
  localparam int PAGE_BYTES = 64;
  localparam int CNT_W      = 7;

  // Positions of the two end-of-write status bits on the byte lines.
  localparam int POLL_BIT   = 7;
  localparam int TOGGLE_BIT = 6;

  // Clock and timing figures; cycles per microsecond come first so the long limit fits 32 bits.
  localparam int CLK_PERIOD_PS = 4000;
  localparam int LOAD_WIN_US   = 100;
  localparam int PROG_TMO_US   = 10000;
  localparam int LOAD_WIN_CYC  = LOAD_WIN_US * ((1000 * 1000) / CLK_PERIOD_PS);
  localparam int PROG_TMO_CYC  = PROG_TMO_US * ((1000 * 1000) / CLK_PERIOD_PS);

  // Pin phase lengths in clock cycles; plain defaults for the bus timing.
  localparam int SETUP_CYC   = 2;
  localparam int WE_LOW_CYC  = 25;
  localparam int RD_CYC      = 16;
  localparam int SYNC_STAGES = 2;
  localparam int RECOVER_CYC = 2;
  localparam int WIN_MARGIN  = SETUP_CYC + 2;

  // Controller states.
  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_WR_SET = 3'b001,
    S_WR_LOW = 3'b010,
    S_WR_END = 3'b011,
    S_PAGE   = 3'b100,
    S_RD_ACT = 3'b101,
    S_RD_END = 3'b110
  } pea_state_t;

endpackage

// File: verilog/pea_host.sv
// Host controller that drives a byte-wide electrically erasable memory through its pins.
//
// Contract
// - A write uses chip select and store strobe low with output enable high.
// - Further bytes may extend a write into a page of up to 64 bytes.
// - All bytes of a page share location bits six through twelve.
// - Each next byte's strobe fall comes within 100 us of the previous fall.
`timescale 1ns/1ps

module pea_host #(
  parameter int unsigned LOAD_WIN_CYC = pea_pkg::LOAD_WIN_CYC,
  parameter int unsigned PROG_TMO_CYC = pea_pkg::PROG_TMO_CYC
) (
  input  wire logic                       core_clk,
  input  wire logic                       srst,
  input  wire logic                       cmd_valid,
  input  wire logic                       cmd_write,
  input  wire logic [pea_pkg::ADDR_W-1:0] cmd_addr,
  input  wire logic [pea_pkg::DATA_W-1:0] cmd_wdata,
  output logic                            cmd_ready,
  output logic                            rsp_valid,
  output logic      [pea_pkg::DATA_W-1:0] rsp_rdata,
  output logic                            wr_done,
  output logic                            wr_timeout,
  output logic                            mem_ce_n,
  output logic                            mem_oe_n,
  output logic                            mem_we_n,
  output logic      [pea_pkg::ADDR_W-1:0] location_select_lines,
  output logic      [pea_pkg::DATA_W-1:0] byte_lines_out,
  output logic                            byte_lines_oe_n,
  input  wire logic [pea_pkg::DATA_W-1:0] byte_lines_in,
  input  wire logic                       supply_low
);
  import pea_pkg::*;

  logic [DATA_W-1:0] bl_meta_r;
  logic [DATA_W-1:0] bl_sync_r;
  logic              sl_meta_r;
  logic              sl_sync_r;

  pea_state_t        state_r,    state_nxt;
  logic [CNT_W-1:0]  cnt_r,      cnt_nxt;
  logic [31:0]       win_r,      win_nxt;
  logic [31:0]       poll_r,     poll_nxt;
  logic [CNT_W-1:0]  nbytes_r,   nbytes_nxt;
  logic [PAGE_W-1:0] page_r,     page_nxt;
  logic [DATA_W-1:0] last_r,     last_nxt;
  logic              polling_r,  polling_nxt;
  logic              have_r,     have_nxt;
  logic              prev6_r,    prev6_nxt;
  logic              ready_r,    ready_nxt;
  logic              rvalid_r,   rvalid_nxt;
  logic [DATA_W-1:0] rdata_r,    rdata_nxt;
  logic              done_r,     done_nxt;
  logic              tmo_r,      tmo_nxt;
  logic              ce_n_r,     ce_n_nxt;
  logic              oe_n_r,     oe_n_nxt;
  logic              we_n_r,     we_n_nxt;
  logic [ADDR_W-1:0] addr_r,     addr_nxt;
  logic [DATA_W-1:0] dout_r,     dout_nxt;
  logic              doe_n_r,    doe_n_nxt;

  logic              take;
  logic              fits;
  logic              time_ok;

  // Pin inputs come from the memory's own timing, so both pass two flops first.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      bl_meta_r <= '0;
      bl_sync_r <= '0;
      sl_meta_r <= 1'b1;
      sl_sync_r <= 1'b1;
    end else begin
      bl_meta_r <= byte_lines_in;
      bl_sync_r <= bl_meta_r;
      sl_meta_r <= supply_low;
      sl_sync_r <= sl_meta_r;
    end
  end

  // A further byte only joins the open page if it keeps the page bits and fits.
  assign take    = cmd_valid && ready_r;
  assign fits    = cmd_write && (cmd_addr[ADDR_W-1:PAGE_LSB] == page_r)
                   && (nbytes_r < CNT_W'(PAGE_BYTES));
  // The margin covers the ready and take cycles and the set-up phase, so the strobe falls at least one cycle inside the window.
  assign time_ok = (win_r + 32'(WIN_MARGIN)) < LOAD_WIN_CYC;

  // Next-state logic for the pin sequencer, page tracker and status poller.
  always_comb begin
    state_nxt   = state_r;
    cnt_nxt     = cnt_r;
    win_nxt     = win_r;
    poll_nxt    = poll_r;
    nbytes_nxt  = nbytes_r;
    page_nxt    = page_r;
    last_nxt    = last_r;
    polling_nxt = polling_r;
    have_nxt    = have_r;
    prev6_nxt   = prev6_r;
    rvalid_nxt  = 1'b0;
    rdata_nxt   = rdata_r;
    done_nxt    = 1'b0;
    tmo_nxt     = tmo_r;
    ce_n_nxt    = ce_n_r;
    oe_n_nxt    = oe_n_r;
    we_n_nxt    = we_n_r;
    addr_nxt    = addr_r;
    dout_nxt    = dout_r;
    doe_n_nxt   = doe_n_r;
    case (state_r)
      S_IDLE, S_PAGE: begin
        if (state_r == S_PAGE) begin
          win_nxt = win_r + 32'd1;
        end
        if (take && cmd_write) begin
          // Select first with the strobe high, so the strobe fall is the later edge.
          addr_nxt   = cmd_addr;
          dout_nxt   = cmd_wdata;
          last_nxt   = cmd_wdata;
          page_nxt   = cmd_addr[ADDR_W-1:PAGE_LSB];
          nbytes_nxt = (state_r == S_PAGE) ? nbytes_r + CNT_W'(1) : CNT_W'(1);
          ce_n_nxt   = 1'b0;
          oe_n_nxt   = 1'b1;
          doe_n_nxt  = 1'b0;
          tmo_nxt    = 1'b0;
          cnt_nxt    = '0;
          state_nxt  = S_WR_SET;
        end else if (take) begin
          addr_nxt    = cmd_addr;
          ce_n_nxt    = 1'b0;
          oe_n_nxt    = 1'b0;
          polling_nxt = 1'b0;
          cnt_nxt     = '0;
          state_nxt   = S_RD_ACT;
        end else if (state_r == S_PAGE && win_r >= LOAD_WIN_CYC) begin
          // The window has run out, so the memory is programming; start polling.
          addr_nxt    = addr_r;
          ce_n_nxt    = 1'b0;
          oe_n_nxt    = 1'b0;
          polling_nxt = 1'b1;
          have_nxt    = 1'b0;
          poll_nxt    = '0;
          cnt_nxt     = '0;
          state_nxt   = S_RD_ACT;
        end
      end
      S_WR_SET: begin
        cnt_nxt = cnt_r + CNT_W'(1);
        if (state_r == S_WR_SET && nbytes_r > CNT_W'(1)) begin
          win_nxt = win_r + 32'd1;
        end
        if (cnt_r == CNT_W'(SETUP_CYC - 1)) begin
          we_n_nxt  = 1'b0;
          win_nxt   = '0;
          cnt_nxt   = '0;
          state_nxt = S_WR_LOW;
        end
      end
      S_WR_LOW: begin
        cnt_nxt = cnt_r + CNT_W'(1);
        win_nxt = win_r + 32'd1;
        if (cnt_r == CNT_W'(WE_LOW_CYC - 1)) begin
          we_n_nxt  = 1'b1;
          cnt_nxt   = '0;
          state_nxt = S_WR_END;
        end
      end
      S_WR_END: begin
        // Data and select stay put past the strobe rise, the earlier rising edge.
        cnt_nxt = cnt_r + CNT_W'(1);
        win_nxt = win_r + 32'd1;
        if (cnt_r == CNT_W'(RECOVER_CYC - 1)) begin
          ce_n_nxt  = 1'b1;
          doe_n_nxt = 1'b1;
          cnt_nxt   = '0;
          state_nxt = S_PAGE;
        end
      end
      S_RD_ACT: begin
        cnt_nxt = cnt_r + CNT_W'(1);
        if (polling_r) begin
          poll_nxt = poll_r + 32'd1;
        end
        if (cnt_r == CNT_W'(RD_CYC + SYNC_STAGES - 1)) begin
          ce_n_nxt  = 1'b1;
          oe_n_nxt  = 1'b1;
          cnt_nxt   = '0;
          state_nxt = S_RD_END;
          if (!polling_r) begin
            rvalid_nxt = 1'b1;
            rdata_nxt  = bl_sync_r;
          end else if (have_r && bl_sync_r[TOGGLE_BIT] == prev6_r
                       && bl_sync_r[POLL_BIT] == last_r[POLL_BIT]) begin
            // Both methods agree, so programming is over.
            done_nxt    = 1'b1;
            polling_nxt = 1'b0;
          end else if (poll_r >= PROG_TMO_CYC) begin
            done_nxt    = 1'b1;
            tmo_nxt     = 1'b1;
            polling_nxt = 1'b0;
          end else begin
            prev6_nxt = bl_sync_r[TOGGLE_BIT];
            have_nxt  = 1'b1;
          end
        end
      end
      S_RD_END: begin
        // Selects go high between polls so that each poll is a separate read.
        cnt_nxt = cnt_r + CNT_W'(1);
        if (polling_r) begin
          poll_nxt = poll_r + 32'd1;
        end
        if (cnt_r == CNT_W'(RECOVER_CYC - 1)) begin
          cnt_nxt = '0;
          if (polling_r) begin
            ce_n_nxt  = 1'b0;
            oe_n_nxt  = 1'b0;
            state_nxt = S_RD_ACT;
          end else begin
            state_nxt = S_IDLE;
          end
        end
      end
      default: begin
        state_nxt = S_IDLE;
        ce_n_nxt  = 1'b1;
        oe_n_nxt  = 1'b1;
        we_n_nxt  = 1'b1;
        doe_n_nxt = 1'b1;
      end
    endcase
    // Ready rises a cycle after an acceptable request appears; writes wait out supply-low.
    ready_nxt = cmd_valid && !take && (!cmd_write || !sl_sync_r)
                && ((state_nxt == S_IDLE)
                    || (state_nxt == S_PAGE && fits && time_ok && !sl_sync_r));
  end

  // Registers; every pin and answer output is taken straight from here.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_r   <= S_IDLE;
      cnt_r     <= '0;
      win_r     <= '0;
      poll_r    <= '0;
      nbytes_r  <= '0;
      page_r    <= '0;
      last_r    <= '0;
      polling_r <= 1'b0;
      have_r    <= 1'b0;
      prev6_r   <= 1'b0;
      ready_r   <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      done_r    <= 1'b0;
      tmo_r     <= 1'b0;
      ce_n_r    <= 1'b1;
      oe_n_r    <= 1'b1;
      we_n_r    <= 1'b1;
      addr_r    <= '0;
      dout_r    <= '0;
      doe_n_r   <= 1'b1;
    end else begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      win_r     <= win_nxt;
      poll_r    <= poll_nxt;
      nbytes_r  <= nbytes_nxt;
      page_r    <= page_nxt;
      last_r    <= last_nxt;
      polling_r <= polling_nxt;
      have_r    <= have_nxt;
      prev6_r   <= prev6_nxt;
      ready_r   <= ready_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      done_r    <= done_nxt;
      tmo_r     <= tmo_nxt;
      ce_n_r    <= ce_n_nxt;
      oe_n_r    <= oe_n_nxt;
      we_n_r    <= we_n_nxt;
      addr_r    <= addr_nxt;
      dout_r    <= dout_nxt;
      doe_n_r   <= doe_n_nxt;
    end
  end

  assign cmd_ready             = ready_r;
  assign rsp_valid             = rvalid_r;
  assign rsp_rdata             = rdata_r;
  assign wr_done               = done_r;
  assign wr_timeout            = tmo_r;
  assign mem_ce_n              = ce_n_r;
  assign mem_oe_n              = oe_n_r;
  assign mem_we_n              = we_n_r;
  assign location_select_lines = addr_r;
  assign byte_lines_out        = dout_r;
  assign byte_lines_oe_n       = doe_n_r;

endmodule

// File: testbench/pea_host_properties.sv
// Pin protocol checker for the memory host controller.
`timescale 1ns/1ps
module pea_host_properties #(
  parameter int unsigned LOAD_WIN_CYC = 200
) (
  input wire logic                       core_clk,
  input wire logic                       srst,
  input wire logic                       cmd_valid,
  input wire logic                       cmd_write,
  input wire logic [pea_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic                       cmd_ready,
  input wire logic                       rsp_valid,
  input wire logic                       wr_done,
  input wire logic                       mem_ce_n,
  input wire logic                       mem_oe_n,
  input wire logic                       mem_we_n,
  input wire logic [pea_pkg::ADDR_W-1:0] location_select_lines,
  input wire logic [pea_pkg::DATA_W-1:0] byte_lines_out,
  input wire logic                       byte_lines_oe_n,
  input wire logic                       supply_low
);
  import pea_pkg::*;
  logic [15:0] since_r, since_nxt;
  logic        we_r, we_nxt;

  // Cycles since the last strobe fall; it saturates, so reset counts as an old fall.
  always_comb begin
    we_nxt = mem_we_n;
    since_nxt = (since_r == 16'hFFFF) ? since_r : since_r + 16'h0001;
    if (we_r && !mem_we_n) begin
      since_nxt = 16'h0000;
    end
  end

  // Registers the counter state.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      since_r <= 16'hFFFF;
      we_r    <= 1'b1;
    end else begin
      since_r <= since_nxt;
      we_r    <= we_nxt;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence rd_take;
    cmd_valid && cmd_ready && !cmd_write;
  endsequence
  sequence rd_pins;
    (!mem_ce_n && !mem_oe_n)[*8];
  endsequence

  no_contend_a: assert property (!byte_lines_oe_n |-> mem_oe_n)
    else $error("host drives byte lines during a read");
  write_pins_a: assert property (!mem_we_n |-> !mem_ce_n && mem_oe_n)
    else $error("strobe low without select or with output enable");
  ce_leads_we_a: assert property ($fell(mem_we_n) |-> $past(!mem_ce_n))
    else $error("strobe fell before select");
  we_rise_first_a: assert property ($rose(mem_we_n) |=> !mem_ce_n)
    else $error("select rose with the strobe");
  data_hold_a: assert property (!mem_we_n |-> !byte_lines_oe_n && $stable(byte_lines_out))
    else $error("write data moved while strobe low");
  read_open_a: assert property (rd_take |=> rd_pins)
    else $error("read did not hold both selects low");
  read_end_a: assert property (rsp_valid |-> $rose(mem_oe_n) && mem_ce_n)
    else $error("read answer without ending the access");
  addr_out_a: assert property (cmd_valid && cmd_ready |=>
    !mem_ce_n && location_select_lines == $past(cmd_addr))
    else $error("taken request not placed on the pins");
  no_early_poll_a: assert property ($fell(mem_oe_n) |-> since_r >= LOAD_WIN_CYC)
    else $error("read inside the byte load window");
  supply_block_a: assert property (supply_low[*8] |=> !$fell(mem_we_n))
    else $error("write started while supply low");
  done_on_ce_a: assert property (wr_done |-> $rose(mem_ce_n) && !rsp_valid)
    else $error("write done not at the end of a poll");
endmodule

bind pea_host pea_host_properties #(.LOAD_WIN_CYC(LOAD_WIN_CYC)) u_chk (.*);

// File: testbench/pea_mem_model.sv
// Behavioural model of the byte-wide memory seen from its pins.
`timescale 1ns/1ps
module pea_mem_model #(
  parameter int WIN  = 150,
  parameter int PROG = 400
) (
  input  wire logic        core_clk,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [12:0] addr,
  input  wire logic [7:0]  din,
  input  wire logic        supply_low,
  output logic      [7:0]  dq
);
  logic [7:0]  mem [0:8191];
  logic [12:0] lat_a;
  logic [7:0]  last_d = 8'h00;
  logic [7:0]  dq_last = 8'h00;
  logic        loading = 1'b0;
  logic        busy = 1'b0;
  logic        tog = 1'b0;
  int          cnt = 0;
  wire         rd = !ce_n && !oe_n;

  // Known contents, so the bench can predict any unwritten location.
  initial for (int i = 0; i < 8192; i++) mem[i] = i[7:0] ^ 8'h5A;

  // Address on the strobe fall; refused while programming or on low supply.
  always @(negedge we_n) if (!ce_n && oe_n && !supply_low && !busy) begin
    lat_a = addr;
    loading = 1'b1;
    cnt = 0;
  end

  // Data on the strobe rise; each load of a page lands in its own byte.
  always @(posedge we_n) if (loading && !ce_n) begin
    mem[lat_a] = din;
    last_d = din;
  end

  // Internal time base for the load window and the programming cycle.
  always @(posedge core_clk) begin
    cnt = cnt + 1;
    if (loading && cnt >= WIN) begin
      loading = 1'b0;
      busy = 1'b1;
      cnt = 0;
    end else if (busy && cnt >= PROG) begin
      busy = 1'b0;
    end
    if (rd) dq_last = dq;
  end

  // Every read start during programming flips the toggle bit.
  always @(posedge rd) if (busy) tog = ~tog;

  // Floating lines show the inverse of the last byte, so stale data never matches.
  assign dq = !rd ? ~dq_last : busy ? {~last_d[7], tog, mem[addr][5:0]} : mem[addr];
endmodule

// File: testbench/test_pea_host.sv
// Self-checking bench for the memory host controller against its memory model.
`timescale 1ns/1ps
module test_pea_host;
  import pea_pkg::*;
  logic              core_clk = 1'b0;
  logic              srst = 1'b1;
  logic              cmd_valid = 1'b0;
  logic              cmd_write = 1'b0;
  logic              supply_low = 1'b0;
  logic [ADDR_W-1:0] cmd_addr = 13'h0000;
  logic [DATA_W-1:0] cmd_wdata = 8'h00;
  logic              cmd_ready, rsp_valid, wr_done, wr_timeout, ce_n, oe_n, we_n, bl_oe_n;
  logic [ADDR_W-1:0] loc;
  logic [DATA_W-1:0] rsp_rdata, bl_out, bl_in, dq;
  int                errors = 0;
  int                compares = 0;
  int                dones = 0;

  always #2 core_clk = ~core_clk;
  // The host wins the lines whenever it enables its drivers.
  assign bl_in = !bl_oe_n ? bl_out : dq;

  pea_host #(.LOAD_WIN_CYC(200), .PROG_TMO_CYC(2000)) dut (
    .core_clk(core_clk), .srst(srst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .wr_done(wr_done),
    .wr_timeout(wr_timeout), .mem_ce_n(ce_n), .mem_oe_n(oe_n), .mem_we_n(we_n),
    .location_select_lines(loc), .byte_lines_out(bl_out), .byte_lines_oe_n(bl_oe_n),
    .byte_lines_in(bl_in), .supply_low(supply_low));
  pea_mem_model far_end (.core_clk(core_clk), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .addr(loc), .din(bl_in), .supply_low(supply_low), .dq(dq));

  // Counts programming completions for the one-per-page check.
  always @(posedge core_clk) if (wr_done === 1'b1) dones++;

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Holds the request until the edge at which ready is seen high.
  task automatic issue(input logic wr, input logic [12:0] a, input logic [7:0] d);
    int n;
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_addr <= a;
    cmd_wdata <= d;
    for (n = 0; n < 5000 && cmd_ready !== 1'b1; n++) @(posedge core_clk) #1;
    check({7'h00, cmd_ready}, 8'h01);
    @(posedge core_clk);
    cmd_valid <= 1'b0;
  endtask

  task automatic do_read(input logic [12:0] a, input logic [7:0] exp);
    int n;
    issue(1'b0, a, 8'h00);
    for (n = 0; n < 100 && rsp_valid !== 1'b1; n++) @(posedge core_clk) #1;
    check({7'h00, rsp_valid}, 8'h01);
    check(rsp_rdata, exp);
  endtask

  task automatic wait_done();
    int n;
    for (n = 0; n < 6000 && wr_done !== 1'b1; n++) @(posedge core_clk) #1;
    check({7'h00, wr_done}, 8'h01);
    // Done must not be claimed while the memory is still programming.
    check({7'h00, far_end.busy}, 8'h00);
    check({7'h00, wr_timeout}, 8'h00);
  endtask

  task automatic t_idle_read();
    check({4'h0, ce_n, oe_n, we_n, bl_oe_n}, 8'h0F);
    do_read(13'h0000, 8'h5A);
    do_read(13'h1FFF, 8'hA5);
  endtask

  task automatic t_byte_write();
    issue(1'b1, 13'h0105, 8'h80);
    wait_done();
    do_read(13'h0105, 8'h80);
  endtask

  task automatic t_page_write();
    int d0;
    d0 = dones;
    issue(1'b1, 13'h0A40, 8'h11);
    issue(1'b1, 13'h0A41, 8'h22);
    issue(1'b1, 13'h0A7F, 8'hF3);
    wait_done();
    do_read(13'h0A40, 8'h11);
    do_read(13'h0A7F, 8'hF3);
    check(8'(dones - d0), 8'h01);
  endtask

  // Supply low must hold a write back until it clears.
  task automatic t_supply_low();
    int hits;
    hits = 0;
    @(posedge core_clk);
    supply_low <= 1'b1;
    repeat (8) @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_write <= 1'b1;
    cmd_addr <= 13'h1234;
    cmd_wdata <= 8'h3C;
    repeat (60) @(posedge core_clk) #1 if (cmd_ready === 1'b1) hits++;
    check(hits[7:0], 8'h00);
    @(posedge core_clk);
    supply_low <= 1'b0;
    issue(1'b1, 13'h1234, 8'h3C);
    wait_done();
    do_read(13'h1234, 8'h3C);
  endtask

  task automatic complete_run();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // A run is a few thousand cycles; the watchdog allows far more.
  initial begin
    #100000;
    errors++;
    complete_run();
  end

  initial begin
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    repeat (4) @(posedge core_clk);
    t_idle_read();
    t_byte_write();
    t_page_write();
    t_supply_low();
    complete_run();
  end
endmodule
